// file: rtl/fesr_pkg.sv
// package for the flash ecc status register block: register map,
// status field layout, reset values, encodings and carrier structs.
// assumes a 32-bit word bus where printed offsets are byte addresses.
package fesr_pkg;

  localparam int DW = 32;

  localparam logic [31:0] ADDR_FLASH_STATUS = 32'h4004_8000;
  localparam logic [31:0] ADDR_IRQ_EN_CTRL = 32'h4004_8004;
  localparam logic [31:0] ADDR_CMD_CODE = 32'h4004_8008;
  localparam logic [31:0] ADDR_KEY_ADDR = 32'h4004_800c;
  localparam logic [31:0] ADDR_KEY_DATA_LO = 32'h4004_8010;
  localparam logic [31:0] ADDR_KEY_DATA_HI = 32'h4004_8014;
  localparam logic [31:0] ADDR_PAGE_LO = 32'h4004_8018;
  localparam logic [31:0] ADDR_PAGE_HI = 32'h4004_801c;
  localparam logic [31:0] ADDR_UNLOCK_KEY = 32'h4004_8020;
  localparam logic [31:0] ADDR_B0_PROT = 32'h4004_8028;
  localparam logic [31:0] ADDR_B1_PROT = 32'h4004_802c;
  localparam logic [31:0] ADDR_SIG_RESULT = 32'h4004_8034;
  localparam logic [31:0] ADDR_USER_SETUP = 32'h4004_8038;
  localparam logic [31:0] ADDR_ABORT_ADDR = 32'h4004_8040;
  localparam logic [31:0] ADDR_ABORT_LO = 32'h4004_8048;
  localparam logic [31:0] ADDR_ABORT_MID = 32'h4004_804c;
  localparam logic [31:0] ADDR_ABORT_HI = 32'h4004_8050;
  localparam logic [31:0] ADDR_ECC_CONFIG = 32'h4004_8064;
  localparam logic [31:0] ADDR_B0_CODE_EA = 32'h4004_8074;
  localparam logic [31:0] ADDR_B1_CODE_EA = 32'h4004_8078;
  localparam logic [31:0] ADDR_B0_DMA_EA = 32'h4004_8094;
  localparam logic [31:0] ADDR_B1_DMA_EA = 32'h4004_8098;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4004_8100;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4004_8104;

  // flash_status field positions and widths
  localparam int STA_D1_CNT_LSB = 29;
  localparam int STA_DMA_RESP_LSB = 27;
  localparam int STA_CODE_RESP_LSB = 25;
  localparam int STA_C1_CNT_LSB = 22;
  localparam int STA_D0_CNT_LSB = 20;
  localparam int STA_C0_CNT_LSB = 17;
  localparam int DMA_CNT_W = 2;
  localparam int CODE_CNT_W = 3;
  localparam int RESP_W = 2;
  localparam int IRQ_EN_W = 3;
  localparam int CMD_W = 5;

  localparam logic [RESP_W-1:0] RESP_NONE = 2'h0;
  localparam logic [RESP_W-1:0] RESP_DOUBLE = 2'h1;
  localparam logic [RESP_W-1:0] RESP_SINGLE = 2'h2;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PROT = 32'h0fff_ffff;
  localparam logic [31:0] RST_USER_SETUP = 32'h0000_0011;
  localparam logic [31:0] RST_ECC_CONFIG = 32'h0000_0012;

  // interrupt status / mask bit layout
  localparam int IRQ_W = 4;
  localparam int IRQ_CODE_SB = 0;
  localparam int IRQ_CODE_DB = 1;
  localparam int IRQ_DMA_SB = 2;
  localparam int IRQ_DMA_DB = 3;

  typedef struct packed {
    logic single;
    logic dbl;
    logic [31:0] addr;
  } fesr_ecc_evt_t;

  typedef struct packed {
    logic [IRQ_EN_W-1:0] irq_en;
    logic [CMD_W-1:0] cmd;
    logic [31:0] key_addr;
    logic [31:0] key_data_lo;
    logic [31:0] key_data_hi;
    logic [31:0] page_lo;
    logic [31:0] page_hi;
    logic [31:0] unlock_key;
    logic [31:0] prot0;
    logic [31:0] prot1;
    logic [31:0] user_setup;
    logic [31:0] abort_lo;
    logic [31:0] abort_mid;
    logic [31:0] abort_hi;
    logic [31:0] ecc_config;
  } fesr_ctrl_t;

endpackage : fesr_pkg

// file: rtl/fesr_sat_cnt.sv
// saturating event counter with clear; an event in the clear cycle
// counts into the fresh window. assumes inc and clr are synchronous.
`timescale 1ns/1ps
`default_nettype none
module fesr_sat_cnt #(
  parameter int W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output var logic [W-1:0] cnt_o
);
  localparam logic [W-1:0] CNT_MAX = '1;
  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_o <= '0;
    end else if (en_i) begin
      if (clr_i) begin
        cnt_o <= inc_i ? CNT_ONE : '0;
      end else if (inc_i && cnt_o != CNT_MAX) begin
        cnt_o <= cnt_o + CNT_ONE;
      end
    end
  end
endmodule : fesr_sat_cnt
`default_nettype wire

// file: rtl/fesr_resp_field.sv
// two-bit ecc response field, cleared on status read.
// a new event beats the clear; a double error beats a single one.
`timescale 1ns/1ps
`default_nettype none
module fesr_resp_field
  import fesr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic single_i,
  input wire logic dbl_i,
  input wire logic clr_i,
  output var logic [RESP_W-1:0] resp_o
);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      resp_o <= RESP_NONE;
    end else if (en_i) begin
      if (dbl_i) begin
        resp_o <= RESP_DOUBLE;
      end else if (single_i) begin
        resp_o <= RESP_SINGLE;
      end else if (clr_i) begin
        resp_o <= RESP_NONE;
      end
    end
  end
endmodule : fesr_resp_field
`default_nettype wire

// file: rtl/fesr_top.sv
// flash controller register set with the ecc result fields of the
// status register, error address capture and an ecc interrupt.
// assumes ecc events and abort captures come from logic on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bank 1 dma-bus extra single-bit errors after the first are counted in status bits 30:29, saturating at 3, doubles ignored.
// - bank 0 dma-bus extra single-bit errors after the first are counted in status bits 21:20, saturating at 3, doubles ignored.
// - the dma-bus response in bits 28:27 reads 01 for a double, 10 for a single, 00 when clean, and clears when read.
// - the code-bus response in bits 26:25 reads 01 for a double, 10 for a single, 00 when clean, and clears when read.
// - bits 24:22 count every single-bit error of code-bus reads of bank 1, not doubles.
// - bits 19:17 count every single-bit error of code-bus reads of bank 0, not doubles.
// - the code-bus counters stop at all ones until cleared.
// - reading the status register zeroes the code-bus counters.
// - the first single-bit error raises the interrupt while counters keep counting until status is read.
// - the user setup register resets to 0x00000011.
// - the ecc configuration register resets to 0x00000012.
// - both write protection registers reset to 0x0FFFFFFF.
// - four read-only registers capture the ecc error address per bank and per bus.
// - three 32-bit registers form the interrupt abort enable mask.
// - two 32-bit registers hold the low and high keyhole write data.
// - a read-only register holds the address of an aborted write.
module fesr_top
  import fesr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [31:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire fesr_ecc_evt_t code0_evt_i,
  input wire fesr_ecc_evt_t code1_evt_i,
  input wire fesr_ecc_evt_t dma0_evt_i,
  input wire fesr_ecc_evt_t dma1_evt_i,
  input wire logic [31:0] sig_i,
  input wire logic abort_evt_i,
  input wire logic [31:0] abort_addr_i,
  output var logic [DW-1:0] rdata_o,
  output var fesr_ctrl_t ctrl_o,
  output var logic irq_o
);

  logic sta_rd;
  logic wr_ok;
  logic code_sb;
  logic code_db;
  logic dma_sb;
  logic dma_db;
  logic [CODE_CNT_W-1:0] cnt_c0;
  logic [CODE_CNT_W-1:0] cnt_c1;
  logic [DMA_CNT_W-1:0] cnt_d0;
  logic [DMA_CNT_W-1:0] cnt_d1;
  logic [RESP_W-1:0] resp_code;
  logic [RESP_W-1:0] resp_dma;
  logic pend_d0_q;
  logic pend_d1_q;
  logic [31:0] ea_c0_q;
  logic [31:0] ea_c1_q;
  logic [31:0] ea_d0_q;
  logic [31:0] ea_d1_q;
  logic [31:0] abort_addr_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [DW-1:0] status_word;
  logic [DW-1:0] rd_mux;

  assign sta_rd = en_i && rd_i && addr_i == ADDR_FLASH_STATUS;
  assign wr_ok = en_i && wr_i;
  assign code_sb = code0_evt_i.single || code1_evt_i.single;
  assign code_db = code0_evt_i.dbl || code1_evt_i.dbl;
  assign dma_sb = dma0_evt_i.single || dma1_evt_i.single;
  assign dma_db = dma0_evt_i.dbl || dma1_evt_i.dbl;

  // code-bus counters count every single error, clear on status read
  fesr_sat_cnt #(
    .W(CODE_CNT_W)
  ) u_cnt_c0 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .inc_i(code0_evt_i.single),
    .clr_i(sta_rd),
    .cnt_o(cnt_c0)
  );
  fesr_sat_cnt #(
    .W(CODE_CNT_W)
  ) u_cnt_c1 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .inc_i(code1_evt_i.single),
    .clr_i(sta_rd),
    .cnt_o(cnt_c1)
  );

  // dma counters see only singles after the first of the window;
  // a single in the read cycle opens the next window instead
  fesr_sat_cnt #(
    .W(DMA_CNT_W)
  ) u_cnt_d0 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .inc_i(dma0_evt_i.single && pend_d0_q && !sta_rd),
    .clr_i(sta_rd),
    .cnt_o(cnt_d0)
  );
  fesr_sat_cnt #(
    .W(DMA_CNT_W)
  ) u_cnt_d1 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .inc_i(dma1_evt_i.single && pend_d1_q && !sta_rd),
    .clr_i(sta_rd),
    .cnt_o(cnt_d1)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pend_d0_q <= 1'b0;
      pend_d1_q <= 1'b0;
    end else if (en_i) begin
      pend_d0_q <= dma0_evt_i.single || (pend_d0_q && !sta_rd);
      pend_d1_q <= dma1_evt_i.single || (pend_d1_q && !sta_rd);
    end
  end

  fesr_resp_field u_resp_code (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .single_i(code_sb),
    .dbl_i(code_db),
    .clr_i(sta_rd),
    .resp_o(resp_code)
  );
  fesr_resp_field u_resp_dma (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .single_i(dma_sb),
    .dbl_i(dma_db),
    .clr_i(sta_rd),
    .resp_o(resp_dma)
  );

  // error addresses follow the latest error of either kind
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ea_c0_q <= RST_ZERO;
      ea_c1_q <= RST_ZERO;
      ea_d0_q <= RST_ZERO;
      ea_d1_q <= RST_ZERO;
    end else if (en_i) begin
      if (code0_evt_i.single || code0_evt_i.dbl) begin
        ea_c0_q <= code0_evt_i.addr;
      end
      if (code1_evt_i.single || code1_evt_i.dbl) begin
        ea_c1_q <= code1_evt_i.addr;
      end
      if (dma0_evt_i.single || dma0_evt_i.dbl) begin
        ea_d0_q <= dma0_evt_i.addr;
      end
      if (dma1_evt_i.single || dma1_evt_i.dbl) begin
        ea_d1_q <= dma1_evt_i.addr;
      end
    end
  end

  // content is undefined at reset; zero is as good as any
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      abort_addr_q <= RST_ZERO;
    end else if (en_i && abort_evt_i) begin
      abort_addr_q <= abort_addr_i;
    end
  end

  // software-written configuration
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
      ctrl_o.prot0 <= RST_PROT;
      ctrl_o.prot1 <= RST_PROT;
      ctrl_o.user_setup <= RST_USER_SETUP;
      ctrl_o.ecc_config <= RST_ECC_CONFIG;
    end else if (wr_ok) begin
      unique case (addr_i)
        ADDR_IRQ_EN_CTRL: ctrl_o.irq_en <= wdata_i[IRQ_EN_W-1:0];
        ADDR_CMD_CODE: ctrl_o.cmd <= wdata_i[CMD_W-1:0];
        ADDR_KEY_ADDR: ctrl_o.key_addr <= wdata_i;
        ADDR_KEY_DATA_LO: ctrl_o.key_data_lo <= wdata_i;
        ADDR_KEY_DATA_HI: ctrl_o.key_data_hi <= wdata_i;
        ADDR_PAGE_LO: ctrl_o.page_lo <= wdata_i;
        ADDR_PAGE_HI: ctrl_o.page_hi <= wdata_i;
        ADDR_UNLOCK_KEY: ctrl_o.unlock_key <= wdata_i;
        ADDR_B0_PROT: ctrl_o.prot0 <= wdata_i;
        ADDR_B1_PROT: ctrl_o.prot1 <= wdata_i;
        ADDR_USER_SETUP: ctrl_o.user_setup <= wdata_i;
        ADDR_ABORT_LO: ctrl_o.abort_lo <= wdata_i;
        ADDR_ABORT_MID: ctrl_o.abort_mid <= wdata_i;
        ADDR_ABORT_HI: ctrl_o.abort_hi <= wdata_i;
        ADDR_ECC_CONFIG: ctrl_o.ecc_config <= wdata_i;
        default: ;
      endcase
    end
  end

  // interrupt: sticky per event kind, write one to clear, set wins
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_CODE_SB] = code_sb;
    irq_evt[IRQ_CODE_DB] = code_db;
    irq_evt[IRQ_DMA_SB] = dma_sb;
    irq_evt[IRQ_DMA_DB] = dma_db;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
    end else if (en_i) begin
      if (wr_i && addr_i == ADDR_IRQ_STATUS) begin
        irq_st_q <= (irq_st_q & ~wdata_i[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_st_q <= irq_st_q | irq_evt;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_mask_q <= '0;
    end else if (wr_ok && addr_i == ADDR_IRQ_MASK) begin
      irq_mask_q <= wdata_i[IRQ_W-1:0];
    end
  end
  // one cycle behind the status bits, keeps the output a flop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (en_i) begin
      irq_o <= |(irq_st_q & irq_mask_q);
    end
  end

  // status word: lower fields belong to the command engine, read zero
  always_comb begin
    status_word = '0;
    status_word[STA_D1_CNT_LSB +: DMA_CNT_W] = cnt_d1;
    status_word[STA_DMA_RESP_LSB +: RESP_W] = resp_dma;
    status_word[STA_CODE_RESP_LSB +: RESP_W] = resp_code;
    status_word[STA_C1_CNT_LSB +: CODE_CNT_W] = cnt_c1;
    status_word[STA_D0_CNT_LSB +: DMA_CNT_W] = cnt_d0;
    status_word[STA_C0_CNT_LSB +: CODE_CNT_W] = cnt_c0;
  end
  always_comb begin
    unique case (addr_i)
      ADDR_FLASH_STATUS: rd_mux = status_word;
      ADDR_IRQ_EN_CTRL: rd_mux = DW'(ctrl_o.irq_en);
      ADDR_CMD_CODE: rd_mux = DW'(ctrl_o.cmd);
      ADDR_KEY_ADDR: rd_mux = ctrl_o.key_addr;
      ADDR_KEY_DATA_LO: rd_mux = ctrl_o.key_data_lo;
      ADDR_KEY_DATA_HI: rd_mux = ctrl_o.key_data_hi;
      ADDR_PAGE_LO: rd_mux = ctrl_o.page_lo;
      ADDR_PAGE_HI: rd_mux = ctrl_o.page_hi;
      ADDR_B0_PROT: rd_mux = ctrl_o.prot0;
      ADDR_B1_PROT: rd_mux = ctrl_o.prot1;
      ADDR_SIG_RESULT: rd_mux = sig_i;
      ADDR_USER_SETUP: rd_mux = ctrl_o.user_setup;
      ADDR_ABORT_ADDR: rd_mux = abort_addr_q;
      ADDR_ABORT_LO: rd_mux = ctrl_o.abort_lo;
      ADDR_ABORT_MID: rd_mux = ctrl_o.abort_mid;
      ADDR_ABORT_HI: rd_mux = ctrl_o.abort_hi;
      ADDR_ECC_CONFIG: rd_mux = ctrl_o.ecc_config;
      ADDR_B0_CODE_EA: rd_mux = ea_c0_q;
      ADDR_B1_CODE_EA: rd_mux = ea_c1_q;
      ADDR_B0_DMA_EA: rd_mux = ea_d0_q;
      ADDR_B1_DMA_EA: rd_mux = ea_d1_q;
      ADDR_IRQ_STATUS: rd_mux = DW'(irq_st_q);
      ADDR_IRQ_MASK: rd_mux = DW'(irq_mask_q);
      default: rd_mux = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (en_i) begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  localparam logic [CODE_CNT_W-1:0] C_MAX = '1;
  localparam logic [DMA_CNT_W-1:0] D_MAX = '1;
  property p_code_sat;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && cnt_c1 == C_MAX && !sta_rd |=> cnt_c1 == C_MAX;
  endproperty
  a_code_sat: assert property (p_code_sat)
    else $error("code counter left saturation without a clear");
  property p_code_clr;
    @(posedge clk_sys_i) disable iff (rst_i)
      sta_rd && !code0_evt_i.single |=> cnt_c0 == '0;
  endproperty
  a_code_clr: assert property (p_code_clr)
    else $error("code counter not cleared by status read");
  property p_code_inc;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && code0_evt_i.single && !sta_rd && cnt_c0 != C_MAX
      |=> cnt_c0 == $past(cnt_c0) + 1'b1;
  endproperty
  a_code_inc: assert property (p_code_inc)
    else $error("code counter missed a single error");
  property p_code_dbl;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && code1_evt_i.dbl && !code1_evt_i.single && !sta_rd
      |=> $stable(cnt_c1);
  endproperty
  a_code_dbl: assert property (p_code_dbl)
    else $error("code counter moved on a double error");
  property p_dma_resp;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && dma_db |=> resp_dma == RESP_DOUBLE;
  endproperty
  a_dma_resp: assert property (p_dma_resp)
    else $error("dma response did not show a double error");
  property p_code_resp;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && code_sb && !code_db ##1 !code_sb && !code_db
      |-> resp_code == RESP_SINGLE;
  endproperty
  a_code_resp: assert property (p_code_resp)
    else $error("code response did not show a single error");
  property p_dma_extra;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && dma1_evt_i.single && pend_d1_q && !sta_rd && cnt_d1 != D_MAX
      |=> cnt_d1 == $past(cnt_d1) + 1'b1;
  endproperty
  a_dma_extra: assert property (p_dma_extra)
    else $error("dma extra counter missed an error");
  property p_dma_first;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && dma0_evt_i.single && !pend_d0_q |=> $stable(cnt_d0);
  endproperty
  a_dma_first: assert property (p_dma_first)
    else $error("dma extra counter counted the first error");
  property p_sta_read;
    @(posedge clk_sys_i) disable iff (rst_i)
      sta_rd |=> rdata_o == $past(status_word);
  endproperty
  a_sta_read: assert property (p_sta_read)
    else $error("status read did not return pre-clear values");
  // a write in the event cycle may legally clear the mask; the bit stays set since set wins
  property p_irq_first;
    @(posedge clk_sys_i) disable iff (rst_i)
      en_i && !wr_i && code_sb && irq_mask_q[IRQ_CODE_SB] ##1 en_i
      |-> ##1 irq_o;
  endproperty
  a_irq_first: assert property (p_irq_first)
    else $error("first single error raised no interrupt");
endmodule : fesr_top
`default_nettype wire

// file: tb/fesr_top_test.sv
// self-checking bench for the flash ecc status register block.
// assumes fesr_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module fesr_top_test
  import fesr_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_i = 1'b1;
  logic [31:0] addr_i = 32'h0000_0000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  fesr_ecc_evt_t ev [4];
  logic [31:0] sig_i = 32'h5a5a_0001;
  logic abort_evt_i = 1'b0;
  logic [31:0] abort_addr_i = 32'h0000_0000;
  logic [31:0] rdata_o;
  fesr_ctrl_t ctrl_o;
  logic irq_o;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rw_a [12];

  fesr_top i_fesr_top (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .code0_evt_i(ev[0]),
    .code1_evt_i(ev[1]),
    .dma0_evt_i(ev[2]),
    .dma1_evt_i(ev[3]),
    .sig_i(sig_i),
    .abort_evt_i(abort_evt_i),
    .abort_addr_i(abort_addr_i),
    .rdata_o(rdata_o),
    .ctrl_o(ctrl_o),
    .irq_o(irq_o)
  );

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // generous ceiling: the whole sequence needs under two hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rdc

  function automatic logic [31:0] ea(input int b);
    return 32'h0000_1000 << b;
  endfunction : ea

  function automatic logic [31:0] sta(input int d1, dr, cr, c1, d0, c0);
    return (32'(d1) << STA_D1_CNT_LSB) | (32'(dr) << STA_DMA_RESP_LSB)
      | (32'(cr) << STA_CODE_RESP_LSB) | (32'(c1) << STA_C1_CNT_LSB)
      | (32'(d0) << STA_D0_CNT_LSB) | (32'(c0) << STA_C0_CNT_LSB);
  endfunction : sta

  // event held for n consecutive cycles on stream b (0 c0,1 c1,2 d0,3 d1)
  task automatic pulse(input int b, input logic s, input logic d,
                       input int n);
    @(posedge clk_sys_i);
    ev[b] <= '{s, d, ea(b)};
    repeat (n) @(posedge clk_sys_i);
    ev[b] <= '0;
  endtask : pulse

  task automatic t_reset();
    rdc(ADDR_USER_SETUP, 32'h0000_0011);
    rdc(ADDR_ECC_CONFIG, 32'h0000_0012);
    rdc(ADDR_B0_PROT, 32'h0fff_ffff);
    rdc(ADDR_B1_PROT, 32'h0fff_ffff);
    chk(ctrl_o.prot1, 32'h0fff_ffff);
    rdc(ADDR_FLASH_STATUS, 32'h0000_0000);
    rdc(ADDR_B0_CODE_EA, 32'h0000_0000);
    rdc(32'h4004_8200, 32'h0000_0000);
  endtask : t_reset

  task automatic t_code1();
    pulse(1, 1'b1, 1'b0, 8);
    pulse(1, 1'b0, 1'b1, 1);
    rdc(ADDR_FLASH_STATUS, sta(0, 0, 1, 7, 0, 0));
    rdc(ADDR_FLASH_STATUS, 32'h0000_0000);
    rdc(ADDR_B1_CODE_EA, ea(1));
  endtask : t_code1

  task automatic t_code0();
    // a frozen block must not see this event
    @(posedge clk_sys_i);
    en_i <= 1'b0;
    pulse(0, 1'b1, 1'b0, 1);
    @(posedge clk_sys_i);
    en_i <= 1'b1;
    pulse(0, 1'b1, 1'b0, 3);
    rdc(ADDR_FLASH_STATUS, sta(0, 0, 2, 0, 0, 3));
    pulse(0, 1'b0, 1'b1, 1);
    rdc(ADDR_FLASH_STATUS, sta(0, 0, 1, 0, 0, 0));
  endtask : t_code0

  task automatic t_dma();
    pulse(3, 1'b1, 1'b0, 6);
    pulse(3, 1'b0, 1'b1, 1);
    rdc(ADDR_FLASH_STATUS, sta(3, 1, 0, 0, 0, 0));
    pulse(2, 1'b1, 1'b0, 2);
    rdc(ADDR_FLASH_STATUS, sta(0, 2, 0, 0, 1, 0));
    rdc(ADDR_FLASH_STATUS, 32'h0000_0000);
    rdc(ADDR_B0_DMA_EA, ea(2));
    rdc(ADDR_B1_DMA_EA, ea(3));
  endtask : t_dma

  // an event in the very cycle of the status read survives the clear
  task automatic t_same_cycle();
    pulse(1, 1'b1, 1'b0, 1);
    @(posedge clk_sys_i);
    ev[1] <= '{1'b1, 1'b0, ea(1)};
    addr_i <= ADDR_FLASH_STATUS;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    ev[1] <= '0;
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, sta(0, 0, 2, 1, 0, 0));
    rdc(ADDR_FLASH_STATUS, sta(0, 0, 2, 1, 0, 0));
  endtask : t_same_cycle

  task automatic t_irq();
    wr(ADDR_IRQ_STATUS, 32'h0000_000f);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000);
    pulse(1, 1'b1, 1'b0, 3);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({31'h0, irq_o}, 32'h0000_0001);
    rdc(ADDR_FLASH_STATUS, sta(0, 0, 2, 3, 0, 0));
    chk({31'h0, irq_o}, 32'h0000_0001);
    pulse(3, 1'b0, 1'b1, 1);
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0008);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rdc(ADDR_IRQ_MASK, 32'h0000_0001);
  endtask : t_irq

  task automatic t_regs();
    rw_a = '{ADDR_ABORT_LO, ADDR_ABORT_MID, ADDR_ABORT_HI,
             ADDR_KEY_DATA_LO, ADDR_KEY_DATA_HI, ADDR_KEY_ADDR,
             ADDR_PAGE_LO, ADDR_PAGE_HI, ADDR_B0_PROT, ADDR_B1_PROT,
             ADDR_USER_SETUP, ADDR_ECC_CONFIG};
    for (int i = 0; i < 12; i++) begin
      wr(rw_a[i], 32'ha5a5_0000 | 32'(i));
    end
    for (int i = 0; i < 12; i++) begin
      rdc(rw_a[i], 32'ha5a5_0000 | 32'(i));
    end
    // narrow registers keep only their own bits
    wr(ADDR_IRQ_EN_CTRL, 32'hffff_ffff);
    wr(ADDR_CMD_CODE, 32'hffff_ffff);
    rdc(ADDR_IRQ_EN_CTRL, 32'h0000_0007);
    rdc(ADDR_CMD_CODE, 32'h0000_001f);
    chk(ctrl_o.abort_hi, 32'ha5a5_0002);
    chk(ctrl_o.key_data_hi, 32'ha5a5_0004);
    @(posedge clk_sys_i);
    abort_addr_i <= 32'h0000_7ff0;
    abort_evt_i <= 1'b1;
    @(posedge clk_sys_i);
    abort_evt_i <= 1'b0;
    wr(ADDR_ABORT_ADDR, 32'h0000_0000);
    rdc(ADDR_ABORT_ADDR, 32'h0000_7ff0);
    wr(ADDR_B0_CODE_EA, 32'h0000_ffff);
    rdc(ADDR_B0_CODE_EA, ea(0));
    wr(ADDR_UNLOCK_KEY, 32'h1234_abcd);
    rdc(ADDR_UNLOCK_KEY, 32'h0000_0000);
    chk(ctrl_o.unlock_key, 32'h1234_abcd);
    rdc(ADDR_SIG_RESULT, 32'h5a5a_0001);
  endtask : t_regs

  // reset in mid-run after every register was overwritten
  task automatic t_mid_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    chk(ctrl_o.unlock_key, 32'h0000_0000);
  endtask : t_mid_reset

  initial begin
    foreach (ev[i]) ev[i] = '0;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_code1();
    t_code0();
    t_dma();
    t_same_cycle();
    t_irq();
    t_regs();
    t_mid_reset();
    end_of_test();
  end

endmodule : fesr_top_test
`default_nettype wire
